// ===== design/ccr_cfg.svh
`ifndef CCR_CFG_SVH
`define CCR_CFG_SVH
// Purpose: Offsets, field positions, reset values and timing figures of the clock ratio block.
// Assumes: Classic Wishbone with 32-bit data, byte addresses.
// Notes: Definitions only.
`define CCR_CLK_MHZ 50
`define CCR_CLK_PERIOD_NS 20
`define CCR_UNIT_CTRL_OFS 4'h0
`define CCR_LB_RATIO_OFS 4'h4
`define CCR_CFG_LOW_OFS 4'h8
`define CCR_CFG_HIGH_OFS 4'hc
`define CCR_SEC_LSB 0
`define CCR_SEC_MSB 1
`define CCR_PCI_BIT 4
`define CCR_LOCAL_BUS_DIVIDER_FIELD_LSB 0
`define CCR_LOCAL_BUS_DIVIDER_FIELD_MSB 3
`define CCR_UNIT_CTRL_RST 32'h0000_0013
`define CCR_LB_RATIO_RST 4'h2
`define CCR_LB_DIV_MIN 4'h2
`define CCR_LOCAL_BUS_CLOCK_MODE_BIT 31
`define CCR_FIRST_MEMORY_CLOCK_MODE_BIT 30
`define CCR_SYSTEM_PLL_MULTIPLIER_MSB 27
`define CCR_SYSTEM_PLL_MULTIPLIER_LSB 24
`define CCR_CORE_PLL_RATIO_MSB 22
`define CCR_CORE_PLL_RATIO_LSB 16
`define CCR_ENGINE_PLL_MULTIPLIER_MSB 12
`define CCR_ENGINE_PLL_MULTIPLIER_LSB 8
`define CCR_ENGINE_PLL_DIVIDER_BIT 6
`define CCR_HOST_BIT 31
`define CCR_PCIDRV_BIT 30
`endif

// ===== design/ccr_clock_ratio.sv
// Purpose: Clock source selection, ratio derivation and per-unit clock control.
// Assumes: core_clk_i is the system bus clock; frequency inputs are in kHz.
// Notes: Derived frequencies are reported as numbers; divided clocks come from flip-flops.
//
// Decided for this implementation: the register offsets and register access over Wishbone.
`timescale 1ns/1ps
`include "ccr_cfg.svh"
module ccr_clock_ratio (
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire logic [31:0] reset_config_word_low_i,
  input wire logic [31:0] reset_config_word_high_i,
  input wire logic cfg_clkin_div_i,
  input wire logic [19:0] clkin_khz_i,
  input wire logic [19:0] pci_sync_khz_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic primary_sel_o,
  output ccr_pkg::ccr_khz_t primary_khz_o,
  output ccr_pkg::ccr_khz_t csb_khz_o,
  output ccr_pkg::ccr_khz_t engine_khz_o,
  output ccr_pkg::ccr_khz_t first_memory_internal_khz_o,
  output ccr_pkg::ccr_khz_t local_bus_internal_khz_o,
  output logic [6:0] core_pll_ratio_o,
  output logic first_memory_bus_clock_out_o,
  output logic first_memory_bus_clock_out_n_o,
  output logic local_bus_sync_output_o,
  output logic [2:0] local_bus_clock_outputs_o,
  output logic sec_clk_en_o,
  output logic pci_dma_clk_en_o,
  output logic cfg_valid_o
);
  import ccr_pkg::*;

  logic cfg_done_r;
  logic [31:0] cfg_low_r;
  logic [31:0] cfg_high_r;
  logic clkin_div_r;
  logic [31:0] unit_ctrl_r;
  logic [3:0] lb_ratio_r;
  logic ack_r;
  logic [31:0] rdata_r;
  logic wb_req;
  logic wr_ctrl;
  logic wr_lb;
  logic [31:0] rdata_nxt;
  logic use_sync;
  logic [3:0] system_pll_multiplier;
  logic [4:0] engine_pll_multiplier;
  logic [20:0] ref_khz;
  logic [24:0] csb_nxt;
  logic [25:0] eng_prod;
  logic [25:0] eng_nxt;
  logic mem_clk_r;
  logic local_bus_internal_clock_r;
  logic [3:0] lb_cnt_r;
  logic [3:0] lb_div_r;
  logic [3:0] lb_half;
  ccr_sec_ratio_t sec_act_r;
  logic [1:0] sec_cnt_r;
  logic [1:0] sec_last;
  logic sec_en_r;
  logic pci_en_r;

  // Straps are caught by a clocked process after reset release, never by the reset itself.
  // latch once
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      cfg_done_r <= 1'b0;
      cfg_low_r <= 32'h0000_0000;
      cfg_high_r <= 32'h0000_0000;
      clkin_div_r <= 1'b0;
    end else if (!cfg_done_r) begin
      cfg_done_r <= 1'b1;
      cfg_low_r <= reset_config_word_low_i;
      cfg_high_r <= reset_config_word_high_i;
      clkin_div_r <= cfg_clkin_div_i;
    end
  end

  assign wb_req = wb_cyc_i && wb_stb_i && !ack_r;
  assign wr_ctrl = wb_req && wb_we_i && (wb_adr_i == `CCR_UNIT_CTRL_OFS);
  assign wr_lb = wb_req && wb_we_i && (wb_adr_i == `CCR_LB_RATIO_OFS) && wb_sel_i[0];

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      ack_r <= 1'b0;
      rdata_r <= 32'h0000_0000;
    end else begin
      ack_r <= wb_req;
      rdata_r <= rdata_nxt;
    end
  end

  // Unmapped addresses answer with zero data and a normal ack.
  always_comb begin
    rdata_nxt = 32'h0000_0000;
    unique case (wb_adr_i)
      `CCR_UNIT_CTRL_OFS: rdata_nxt = unit_ctrl_r;
      `CCR_LB_RATIO_OFS: rdata_nxt = {28'h000_0000, lb_ratio_r};
      `CCR_CFG_LOW_OFS: rdata_nxt = cfg_low_r;
      `CCR_CFG_HIGH_OFS: rdata_nxt = cfg_high_r;
      default: rdata_nxt = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      unit_ctrl_r <= `CCR_UNIT_CTRL_RST;
    end else if (wr_ctrl && wb_sel_i[0]) begin
      unit_ctrl_r[`CCR_SEC_MSB:`CCR_SEC_LSB] <= wb_dat_i[`CCR_SEC_MSB:`CCR_SEC_LSB];
      unit_ctrl_r[`CCR_PCI_BIT] <= wb_dat_i[`CCR_PCI_BIT];
    end
  end

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      lb_ratio_r <= `CCR_LB_RATIO_RST;
    end else if (wr_lb) begin
      lb_ratio_r <= wb_dat_i[`CCR_LOCAL_BUS_DIVIDER_FIELD_MSB:`CCR_LOCAL_BUS_DIVIDER_FIELD_LSB];
    end
  end

  assign wb_ack_o = ack_r;
  assign wb_dat_o = rdata_r;

  assign use_sync = cfg_high_r[`CCR_HOST_BIT] && !cfg_high_r[`CCR_PCIDRV_BIT];
  assign system_pll_multiplier = cfg_low_r[`CCR_SYSTEM_PLL_MULTIPLIER_MSB:`CCR_SYSTEM_PLL_MULTIPLIER_LSB];
  assign engine_pll_multiplier = cfg_low_r[`CCR_ENGINE_PLL_MULTIPLIER_MSB:`CCR_ENGINE_PLL_MULTIPLIER_LSB];
  assign ref_khz = clkin_div_r ? {pci_sync_khz_i, 1'b0} : {1'b0, pci_sync_khz_i};
  assign csb_nxt = 25'(ref_khz * system_pll_multiplier);
  assign eng_prod = 26'((use_sync ? pci_sync_khz_i : clkin_khz_i) * engine_pll_multiplier);
  assign eng_nxt = cfg_low_r[`CCR_ENGINE_PLL_DIVIDER_BIT] ? {1'b0, eng_prod[25:1]} : eng_prod;

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      primary_sel_o <= 1'b0;
      primary_khz_o <= 32'h0000_0000;
      csb_khz_o <= 32'h0000_0000;
      engine_khz_o <= 32'h0000_0000;
      first_memory_internal_khz_o <= 32'h0000_0000;
      local_bus_internal_khz_o <= 32'h0000_0000;
      core_pll_ratio_o <= 7'h00;
    end else begin
      primary_sel_o <= use_sync;
      primary_khz_o <= {12'h000, use_sync ? pci_sync_khz_i : clkin_khz_i};
      csb_khz_o <= {7'h00, csb_nxt};
      engine_khz_o <= {6'h00, eng_nxt};
      first_memory_internal_khz_o <= cfg_low_r[`CCR_FIRST_MEMORY_CLOCK_MODE_BIT] ?
        {6'h00, csb_nxt, 1'b0} : {7'h00, csb_nxt};
      local_bus_internal_khz_o <= cfg_low_r[`CCR_LOCAL_BUS_CLOCK_MODE_BIT] ?
        {6'h00, csb_nxt, 1'b0} : {7'h00, csb_nxt};
      core_pll_ratio_o <= cfg_low_r[`CCR_CORE_PLL_RATIO_MSB:`CCR_CORE_PLL_RATIO_LSB];
    end
  end

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      mem_clk_r <= 1'b0;
    end else begin
      mem_clk_r <= !mem_clk_r;
    end
  end

  assign first_memory_bus_clock_out_o = mem_clk_r;
  assign first_memory_bus_clock_out_n_o = !mem_clk_r;

  // A new divide ratio is taken only at the end of a low phase so no pulse is shortened.
  assign lb_half = lb_div_r >> 1;

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      local_bus_internal_clock_r <= 1'b0;
      lb_cnt_r <= 4'h0;
      lb_div_r <= `CCR_LB_RATIO_RST;
    end else if (lb_cnt_r >= lb_half - 4'h1) begin
      lb_cnt_r <= 4'h0;
      local_bus_internal_clock_r <= !local_bus_internal_clock_r;
      if (!local_bus_internal_clock_r) begin
        lb_div_r <= (lb_ratio_r < `CCR_LB_DIV_MIN) ? `CCR_LB_DIV_MIN : lb_ratio_r;
      end
    end else begin
      lb_cnt_r <= lb_cnt_r + 4'h1;
    end
  end

  assign local_bus_sync_output_o = local_bus_internal_clock_r;
  assign local_bus_clock_outputs_o = {3{local_bus_internal_clock_r}};

  always_comb begin
    unique case (sec_act_r)
      CCR_SEC_HALF: sec_last = 2'h1;
      CCR_SEC_THIRD: sec_last = 2'h2;
      default: sec_last = 2'h0;
    endcase
  end

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      sec_act_r <= CCR_SEC_THIRD;
      sec_cnt_r <= 2'h0;
      sec_en_r <= 1'b0;
    end else begin
      if (sec_cnt_r >= sec_last) begin
        sec_cnt_r <= 2'h0;
        sec_act_r <= ccr_sec_ratio_t'(unit_ctrl_r[`CCR_SEC_MSB:`CCR_SEC_LSB]);
      end else begin
        sec_cnt_r <= sec_cnt_r + 2'h1;
      end
      sec_en_r <= (sec_act_r != CCR_SEC_OFF) && (sec_cnt_r == 2'h0);
    end
  end

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      pci_en_r <= 1'b0;
    end else begin
      pci_en_r <= unit_ctrl_r[`CCR_PCI_BIT];
    end
  end

  assign sec_clk_en_o = sec_en_r;
  assign pci_dma_clk_en_o = pci_en_r;
  assign cfg_valid_o = cfg_done_r;

  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (rst_i);

  sequence sec_gap2_s;
    !sec_clk_en_o [*2];
  endsequence

  // The divider runs from reset release; the check only starts after strap capture, so the first edge after release is skipped.
  mem_clk_half_a: assert property (cfg_done_r |->
    $changed(first_memory_bus_clock_out_o) &&
    (first_memory_bus_clock_out_n_o == !first_memory_bus_clock_out_o))
    else $error("memory bus clock not half rate differential");
  cfg_word_hold_a: assert property ($past(cfg_done_r) |-> $stable(cfg_low_r) &&
    $stable(cfg_high_r)) else $error("configuration word changed after latch");
  primary_source_a: assert property (cfg_done_r |=> primary_sel_o ==
    ($past(cfg_high_r[`CCR_HOST_BIT]) && !$past(cfg_high_r[`CCR_PCIDRV_BIT])))
    else $error("primary clock source wrong");
  // The output lags its inputs by one edge, so every input must be steady across that edge.
  csb_product_a: assert property ($stable(pci_sync_khz_i) && $stable(cfg_low_r) &&
    $stable(clkin_div_r) |-> csb_khz_o == 32'(pci_sync_khz_i * (32'h1 + 32'(clkin_div_r))
    * system_pll_multiplier)) else $error("bus clock frequency wrong");
  memory_ratio_a: assert property (first_memory_internal_khz_o ==
    (cfg_low_r[`CCR_FIRST_MEMORY_CLOCK_MODE_BIT] ? csb_khz_o << 1 : csb_khz_o) || !$past(cfg_done_r, 2))
    else $error("memory clock ratio wrong");
  lb_ratio_a: assert property (local_bus_internal_khz_o ==
    (cfg_low_r[`CCR_LOCAL_BUS_CLOCK_MODE_BIT] ? csb_khz_o << 1 : csb_khz_o) || !$past(cfg_done_r, 2))
    else $error("local-bus clock ratio wrong");
  // A ratio written during a period takes over at its end, so the closing pulse follows it.
  sec_third_a: assert property (sec_clk_en_o && sec_act_r == CCR_SEC_THIRD &&
    $past(sec_act_r) == CCR_SEC_THIRD |=> sec_gap2_s ##1
    (sec_clk_en_o == ($past(sec_act_r) != CCR_SEC_OFF)))
    else $error("security clock not divided by three");
  sec_off_a: assert property (sec_act_r == CCR_SEC_OFF [*2] |-> !sec_clk_en_o)
    else $error("security clock pulses while off");
  pci_gate_a: assert property ($fell(unit_ctrl_r[`CCR_PCI_BIT]) |=> !pci_dma_clk_en_o)
    else $error("PCI/DMA clock not gated");
  lb_outputs_a: assert property (lb_div_r == 4'h2 && $changed(local_bus_internal_clock_r) &&
    $past(lb_div_r) == 4'h2 |=> $changed(local_bus_internal_clock_r))
    else $error("local-bus divide by two wrong");
  wb_ack_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o)
    else $error("bus ack not single cycle");
endmodule // ccr_clock_ratio

// ===== design/ccr_pkg.sv
// Purpose: Types shared by the clock ratio block.
// Assumes: Nothing beyond the configuration header.
// Notes: Encodings of the security core ratio field.
package ccr_pkg;
  typedef enum logic [1:0] {
    CCR_SEC_OFF = 2'h0,
    CCR_SEC_FULL = 2'h1,
    CCR_SEC_HALF = 2'h2,
    CCR_SEC_THIRD = 2'h3
  } ccr_sec_ratio_t;
  typedef logic [31:0] ccr_khz_t;
endpackage

// ===== dv/ccr_board_model.sv
// Purpose: Board clock source and reset configuration word source.
// Assumes: Straps are plain levels; frequencies are given in kHz.
// Notes: The agent set is raised only after capture, to probe strap latching.
`timescale 1ns/1ps
module ccr_board_model (
  input wire logic agent_i,
  output logic [31:0] reset_config_word_low_o,
  output logic [31:0] reset_config_word_high_o,
  output logic cfg_clkin_div_o,
  output logic [19:0] clkin_khz_o,
  output logic [19:0] pci_sync_khz_o
);
  assign reset_config_word_low_o = agent_i ?
    {1'b1, 1'b0, 2'h0, 4'h5, 1'b0, 7'h04, 3'h0, 5'h07, 1'b0, 1'b0, 6'h00} :
    {1'b0, 1'b1, 2'h0, 4'h2, 1'b0, 7'h03, 3'h0, 5'h05, 1'b0, 1'b1, 6'h00};
  assign reset_config_word_high_o = {~agent_i, 31'h0};
  assign cfg_clkin_div_o = ~agent_i;
  assign clkin_khz_o = agent_i ? 20'h00000 : 20'h101d0;
  assign pci_sync_khz_o = 20'h080e8;
endmodule // ccr_board_model

// ===== dv/ccr_clock_ratio_tb.sv
// Purpose: Self-checking bench for the clock ratio block.
// Assumes: Wishbone answer comes one cycle after the taking edge.
// Notes: Expected figures follow from the board model strap codes.
`timescale 1ns/1ps
`include "ccr_cfg.svh"
module ccr_clock_ratio_tb;
  import ccr_pkg::*;
  logic core_clk_i, rst_i, agent, cyc, stb, we, div;
  logic ack, psel, mp, mn, lsync, sec, pci, cval;
  logic [3:0] adr;
  logic [31:0] dat, q, lo, hi, rd;
  logic [19:0] ck, sy;
  logic [2:0] local_bus_clock_outputs;
  logic [6:0] cpll;
  ccr_khz_t pk, bk, ek, dk, lk;
  int miscompares = 0;
  int num_checks = 0;
  ccr_board_model i_ccr_board_model (.agent_i(agent), .reset_config_word_low_o(lo),
    .reset_config_word_high_o(hi), .cfg_clkin_div_o(div), .clkin_khz_o(ck),
    .pci_sync_khz_o(sy));
  ccr_clock_ratio i_ccr_clock_ratio (.core_clk_i(core_clk_i), .rst_i(rst_i),
    .reset_config_word_low_i(lo), .reset_config_word_high_i(hi), .cfg_clkin_div_i(div),
    .clkin_khz_i(ck), .pci_sync_khz_i(sy), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(dat), .wb_dat_o(rd), .wb_ack_o(ack),
    .primary_sel_o(psel), .primary_khz_o(pk), .csb_khz_o(bk), .engine_khz_o(ek),
    .first_memory_internal_khz_o(dk), .local_bus_internal_khz_o(lk),
    .core_pll_ratio_o(cpll), .first_memory_bus_clock_out_o(mp),
    .first_memory_bus_clock_out_n_o(mn), .local_bus_sync_output_o(lsync),
    .local_bus_clock_outputs_o(local_bus_clock_outputs), .sec_clk_en_o(sec), .pci_dma_clk_en_o(pci),
    .cfg_valid_o(cval));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    num_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] %0t %s got %h", $time, m, got);
    end
  endtask
  task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
    @(posedge core_clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat <= d;
    do @(posedge core_clk_i); while (ack !== 1'b1);
    q = rd;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask
  // Counts security pulses and local-bus clock toggles over n edges.
  task automatic run(input int n, output int s, output int t);
    logic p;
    p = lsync;
    s = 0;
    t = 0;
    repeat (n) begin
      @(posedge core_clk_i);
      s += int'(sec);
      t += int'(lsync !== p);
      p = lsync;
    end
  endtask
  task automatic t_cfg();
    chk(cval, 1, "config valid");
    chk(psel, 1, "primary select");
    chk(pk, 32'h0000_80e8, "primary kHz");
    chk(bk, 32'h0002_03a0, "bus kHz");
    chk(ek, 32'h0001_4244, "engine kHz");
    chk(dk, 32'h0004_0740, "memory kHz");
    chk(lk, 32'h0002_03a0, "local kHz");
    chk(cpll, 32'h3, "core ratio");
  endtask
  task automatic t_regs();
    wb(0, `CCR_UNIT_CTRL_OFS, 0);
    chk(q, `CCR_UNIT_CTRL_RST, "unit reset");
    wb(0, `CCR_LB_RATIO_OFS, 0);
    chk(q[3:0], `CCR_LB_RATIO_RST, "divider reset");
    wb(1, `CCR_CFG_LOW_OFS, ~lo);
    wb(0, `CCR_CFG_LOW_OFS, 0);
    chk(q, lo, "low word");
    wb(0, `CCR_CFG_HIGH_OFS, 0);
    chk(q, hi, "high word");
  endtask
  task automatic t_sec();
    int s, t;
    int e[4] = '{0, 12, 6, 4};
    run(12, s, t);
    chk(s, 4, "default third");
    for (int r = 0; r < 4; r++) begin
      wb(1, `CCR_UNIT_CTRL_OFS, 32'h10 | 32'(r));
      run(6, s, t);
      run(12, s, t);
      chk(s, e[r], "security pulses");
    end
  endtask
  task automatic t_pci();
    wb(1, `CCR_UNIT_CTRL_OFS, 32'h3);
    repeat (2) @(posedge core_clk_i);
    chk(pci, 0, "pci off");
    wb(1, `CCR_UNIT_CTRL_OFS, 32'h13);
    repeat (2) @(posedge core_clk_i);
    chk(pci, 1, "pci on");
  endtask
  task automatic t_mem();
    logic p;
    p = mp;
    repeat (8) begin
      @(posedge core_clk_i);
      chk(mp ^ p, 1, "memory clock toggle");
      chk(mn ^ mp, 1, "memory clock pair");
      p = mp;
    end
  endtask
  task automatic t_lb();
    int s, t;
    int d[4] = '{0, 2, 4, 6};
    int e[4] = '{24, 24, 12, 8};
    for (int i = 0; i < 4; i++) begin
      wb(1, `CCR_LB_RATIO_OFS, 32'(d[i]));
      run(8, s, t);
      run(24, s, t);
      chk(t, e[i], "local toggles");
      chk(local_bus_clock_outputs, {3{lsync}}, "local outputs");
    end
  endtask
  // A second reset with the agent straps selects the plain input as primary clock.
  task automatic t_agent();
    rst_i <= 1'b1;
    repeat (2) @(posedge core_clk_i);
    rst_i <= 1'b0;
    repeat (3) @(posedge core_clk_i);
    chk(cval, 1, "agent config valid");
    chk(psel, 0, "agent primary select");
    chk(pk, 32'h0000_0000, "agent primary kHz");
    chk(bk, 32'h0002_8488, "agent bus kHz");
    chk(ek, 32'h0000_0000, "agent engine kHz");
    chk(dk, 32'h0002_8488, "agent memory kHz");
    chk(lk, 32'h0005_0910, "agent local kHz");
    chk(cpll, 32'h4, "agent core ratio");
  endtask
  task automatic final_report();
    if (miscompares == 0 && num_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  initial begin
    core_clk_i = 1'b0;
    forever #10 core_clk_i = ~core_clk_i;
  end
  initial begin
    rst_i = 1'b1;
    agent = 1'b0;
    cyc = 1'b0;
    stb = 1'b0;
    we = 1'b0;
    adr = 4'h0;
    dat = 32'h0;
    repeat (20) @(posedge core_clk_i);
    rst_i <= 1'b0;
    repeat (3) @(posedge core_clk_i);
    t_cfg();
    t_regs();
    t_sec();
    t_pci();
    t_mem();
    t_lb();
    agent <= 1'b1;
    repeat (4) @(posedge core_clk_i);
    t_cfg();
    t_agent();
    final_report();
  end
  initial begin
    #400000;
    miscompares++;
    final_report();
  end
endmodule // ccr_clock_ratio_tb
